// >>> pom_pkg.sv
/*
  Shared constants and carrier types for the path overhead monitor and diagnostic block.
  Assumes one 100 MHz clock and APB register access with word-aligned registers.
*/
package pom_pkg;

  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_LOAD_METERS = 8'h00;
  localparam logic [7:0] IDX_PATH_LABEL = 8'h37;
  localparam logic [7:0] IDX_BIP_LOW = 8'h38;
  localparam logic [7:0] IDX_BIP_HIGH = 8'h39;
  localparam logic [7:0] IDX_FAR_LOW = 8'h3a;
  localparam logic [7:0] IDX_FAR_HIGH = 8'h3b;
  localparam logic [7:0] IDX_AUX_DEFECT_CTRL = 8'h3c;
  localparam logic [7:0] IDX_RX_RING_CTRL = 8'h3d;
  localparam logic [7:0] IDX_TX_PATH_DIAG_CTRL = 8'h40;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h48;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h49;
  localparam logic [7:0] IDX_STREAM_CFG = 8'h4a;

  // aux_defect_ctrl fields
  localparam int AUX_STATE_BIT = 0;
  localparam int AUX_IRQ_EN_BIT = 1;
  localparam int AUX_RSVD_LO_BIT = 2;
  localparam int FAR_BLOCK_BIT = 4;
  localparam int AUX_RSVD_HI_BIT = 5;
  // rx_ring_ctrl fields
  localparam int BIP_REPORT_BLOCK_BIT = 3;
  localparam int RX_STUFF_SKIP_BIT = 4;
  localparam int BIP_COUNT_BLOCK_BIT = 5;
  localparam int SIZE_CHECK_BIT = 6;
  localparam int STUFF_SPACING_BIT = 7;
  // tx_path_diag_ctrl fields
  localparam int ALARM_FORCE_BIT = 0;
  localparam int B3_INVERT_BIT = 1;
  localparam int TX_STUFF_SKIP_BIT = 3;
  // interrupt status and mask fields
  localparam int IRQ_AUX_BIT = 0;
  localparam int IRQ_LABEL_BIT = 1;
  localparam int IRQ_BIP_BIT = 2;
  localparam int IRQ_FAR_BIT = 3;

  // reset values
  localparam logic [7:0] RING_CTRL_RESET = 8'h00;
  localparam logic [7:0] AUX_CTRL_RESET = 8'h00;
  localparam logic [3:0] TX_CTRL_RESET = 4'h0;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  localparam logic [7:0] LABEL_RESET = 8'h00;

  // stream constants
  localparam logic [6:0] FIXED_STUFF_COL_A = 7'h1e;
  localparam logic [6:0] FIXED_STUFF_COL_B = 7'h3b;
  localparam logic [2:0] AUX_FILTER_FRAMES = 3'h5;
  localparam logic [1:0] STUFF_SPACING_FRAMES = 2'h3;
  localparam logic [1:0] SIZE_BITS_OK = 2'h2;
  localparam logic [3:0] FAR_CODE_MAX = 4'h8;

  // poll transfer deadline
  localparam int POLL_TIME_US = 7;
  localparam int CLOCK_MHZ = 100;
  localparam int POLL_MAX_CYCLES = POLL_TIME_US * CLOCK_MHZ;

  // one byte of the path stream with its position qualifiers
  typedef struct packed {
    logic frame_start;
    logic valid;
    logic [6:0] col;
    logic spe;
    logic ptr;
    logic c2;
    logic g1;
    logic b3;
    logic [7:0] data;
  } pom_byte_t;

  // raw indications from the pointer interpreter
  typedef struct packed {
    logic new_flag_ind;
    logic inc_ind;
    logic dec_ind;
    logic new_point;
    logic [1:0] size_bits;
  } pom_ptr_raw_t;

  typedef struct packed {
    logic new_flag_ind;
    logic inc_ind;
    logic dec_ind;
    logic new_point;
  } pom_ptr_ind_t;

  // bip errors handed to the transmit path processor
  typedef struct packed {
    logic valid;
    logic [3:0] count;
  } pom_bip_rpt_t;

endpackage

// >>> pom_err_counter.sv
/*
  Error accumulator with a snapshot register for polling.
  Assumes snap_in is a one-cycle pulse on the same clock.
*/
module pom_err_counter
  import pom_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // events and poll
  input wire logic [3:0] inc_in,
  input wire logic snap_in,
  // snapshot
  output logic [15:0] count_out
);

  logic [15:0] acc_r, acc_nxt;
  logic [15:0] count_r, count_nxt;
  logic [16:0] sum;

  always_comb begin
    sum = {1'b0, acc_r} + {13'h0000, inc_in};
    // saturate rather than wrap so a long interval never reads as few errors
    if (sum[16]) begin
      sum = 17'h0ffff;
    end
    acc_nxt = sum[15:0];
    count_nxt = count_r;
    if (snap_in) begin
      count_nxt = sum[15:0];
      acc_nxt = 16'h0000;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      acc_r <= 16'h0000;
      count_r <= 16'h0000;
    end else begin
      acc_r <= acc_nxt;
      count_r <= count_nxt;
    end
  end

  assign count_out = count_r;

endmodule

// >>> pom_label_filter.sv
/*
  Two-frame debounce of the received path signal label byte.
  Assumes label_valid_in marks the label byte once per frame.
*/
module pom_label_filter
  import pom_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // received label byte
  input wire logic label_valid_in,
  input wire logic [7:0] label_in,
  // accepted label
  output logic [7:0] label_value_out,
  output logic change_out
);

  logic [7:0] cand_r, cand_nxt;
  logic [7:0] label_r, label_nxt;
  logic change_r, change_nxt;

  always_comb begin
    cand_nxt = cand_r;
    label_nxt = label_r;
    change_nxt = 1'b0;
    if (label_valid_in) begin
      cand_nxt = label_in;
      if (label_in == cand_r && label_in != label_r) begin
        label_nxt = label_in;
        change_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      cand_r <= LABEL_RESET;
      label_r <= LABEL_RESET;
      change_r <= 1'b0;
    end else begin
      cand_r <= cand_nxt;
      label_r <= label_nxt;
      change_r <= change_nxt;
    end
  end

  assign label_value_out = label_r;
  assign change_out = change_r;

endmodule

// >>> pom_top.sv
/*
  Path overhead monitor and transmit diagnostic insertion with an APB register slave.
  Assumes stream bytes, pointer indications and APB on clock_in; path_alarm_in is asynchronous.
*/
// How it works
// - label changes after two equal new frames
// - bip count is sixteen bits, two bytes
// - counter write snapshots counts, restarts from zero
// - coincident event lands in old interval
// - global load write polls every counter
// - far error count is sixteen bits, two bytes
// - read-only bit shows aux defect state
// - enabled aux defect change drives irq low
// - far block mode: one per code 1..8
// - bip report: block or per bit
// - rx skips fixed stuff unless sts3c
// - bip count: block or per bit
// - bad size bits suppress pointer indications
// - inc/dec need three frames since change
// - alarm force or input fills all ones
// - b3 invert overrides external error mask
// - tx skips columns 30, 59 if set, unless sts3c
module pom_top
  import pom_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  // receive stream and pointer interpreter
  input wire pom_byte_t rx_byte_in,
  input wire pom_ptr_raw_t ptr_raw_in,
  output pom_ptr_ind_t ptr_ind_out,
  output pom_bip_rpt_t bip_rpt_out,
  // transmit stream
  input wire pom_byte_t tx_byte_in,
  input wire logic path_alarm_in,
  input wire logic tx_overhead_insert_en_in,
  input wire logic [7:0] tx_b3_mask_in,
  output pom_byte_t tx_byte_out,
  // interrupt
  output logic irq_n_out
);

  function automatic logic [3:0] ones8(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  function automatic logic is_stuff_col(input logic [6:0] col);
    return (col == FIXED_STUFF_COL_A) || (col == FIXED_STUFF_COL_B);
  endfunction

  // ---------------- apb and registers ----------------
  logic pready_r, pready_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [7:0] aux_ctrl_r, aux_ctrl_nxt;
  logic [7:0] ring_r, ring_nxt;
  logic [3:0] tx_ctrl_r, tx_ctrl_nxt;
  logic [3:0] irq_status_r, irq_status_nxt;
  logic [3:0] irq_mask_r, irq_mask_nxt;
  logic sts3c_r, sts3c_nxt;
  logic poll_r, poll_nxt;
  logic irq_n_r, irq_n_nxt;
  logic [7:0] idx;
  logic idx_ok;
  logic wr_take;
  logic [3:0] events;
  logic [7:0] label_value;
  logic label_change;
  logic [15:0] bip_err_count;
  logic [15:0] far_err_count;
  logic aux_defect_state_r;
  logic aux_change_r;
  logic bip_event_r;
  logic far_event_r;
  logic [3:0] bip_inc_r;
  logic [3:0] far_inc_r;

  assign idx = paddr_in[9:2];
  assign idx_ok = (paddr_in[11:10] == 2'h0) && (paddr_in[1:0] == 2'h0);
  assign wr_take = psel_in && penable_in && pready_r && pwrite_in;
  assign events = {far_event_r, bip_event_r, label_change, aux_change_r};

  always_comb begin
    pready_nxt = psel_in && penable_in && !pready_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    aux_ctrl_nxt = aux_ctrl_r;
    ring_nxt = ring_r;
    tx_ctrl_nxt = tx_ctrl_r;
    irq_mask_nxt = irq_mask_r;
    sts3c_nxt = sts3c_r;
    poll_nxt = 1'b0;
    irq_status_nxt = irq_status_r;
    if (pready_nxt) begin
      prdata_nxt = 32'h0000_0000;
      pslverr_nxt = !idx_ok;
      if (idx_ok) begin
        case (idx)
          IDX_LOAD_METERS: prdata_nxt = 32'h0000_0000;
          IDX_PATH_LABEL: prdata_nxt[7:0] = label_value;
          IDX_BIP_LOW: prdata_nxt[7:0] = bip_err_count[7:0];
          IDX_BIP_HIGH: prdata_nxt[7:0] = bip_err_count[15:8];
          IDX_FAR_LOW: prdata_nxt[7:0] = far_err_count[7:0];
          IDX_FAR_HIGH: prdata_nxt[7:0] = far_err_count[15:8];
          IDX_AUX_DEFECT_CTRL: begin
            prdata_nxt[7:0] = aux_ctrl_r;
            prdata_nxt[AUX_IRQ_EN_BIT] = irq_mask_r[IRQ_AUX_BIT];
            prdata_nxt[AUX_STATE_BIT] = aux_defect_state_r;
          end
          IDX_RX_RING_CTRL: prdata_nxt[7:0] = ring_r;
          IDX_TX_PATH_DIAG_CTRL: prdata_nxt[3:0] = tx_ctrl_r;
          IDX_IRQ_STATUS: prdata_nxt[3:0] = irq_status_r;
          IDX_IRQ_MASK: prdata_nxt[3:0] = irq_mask_r;
          IDX_STREAM_CFG: prdata_nxt[0] = sts3c_r;
          default: pslverr_nxt = 1'b1;
        endcase
      end
    end
    if (wr_take && idx_ok) begin
      case (idx)
        IDX_LOAD_METERS: poll_nxt = 1'b1;
        IDX_BIP_LOW, IDX_BIP_HIGH, IDX_FAR_LOW, IDX_FAR_HIGH: poll_nxt = 1'b1;
        IDX_AUX_DEFECT_CTRL: begin
          // reserved bits 2 and 5 are stored as written, reserved bits 3, 6 and 7 are dropped; software keeps them zero
          aux_ctrl_nxt = pwdata_in[7:0] & 8'h34;
          irq_mask_nxt[IRQ_AUX_BIT] = pwdata_in[AUX_IRQ_EN_BIT];
        end
        IDX_RX_RING_CTRL: ring_nxt = pwdata_in[7:0];
        IDX_TX_PATH_DIAG_CTRL: tx_ctrl_nxt = pwdata_in[3:0];
        IDX_IRQ_STATUS: irq_status_nxt = irq_status_r & ~pwdata_in[3:0];
        IDX_IRQ_MASK: irq_mask_nxt = pwdata_in[3:0];
        IDX_STREAM_CFG: sts3c_nxt = pwdata_in[0];
        default: poll_nxt = 1'b0;
      endcase
    end
    // a new event wins over a simultaneous write-one clear
    irq_status_nxt = irq_status_nxt | events;
    irq_n_nxt = !(|(irq_status_nxt & irq_mask_nxt));
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      aux_ctrl_r <= AUX_CTRL_RESET;
      ring_r <= RING_CTRL_RESET;
      tx_ctrl_r <= TX_CTRL_RESET;
      irq_status_r <= IRQ_RESET;
      irq_mask_r <= IRQ_RESET;
      sts3c_r <= 1'b0;
      poll_r <= 1'b0;
      irq_n_r <= 1'b1;
    end else begin
      pready_r <= pready_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      aux_ctrl_r <= aux_ctrl_nxt;
      ring_r <= ring_nxt;
      tx_ctrl_r <= tx_ctrl_nxt;
      irq_status_r <= irq_status_nxt;
      irq_mask_r <= irq_mask_nxt;
      sts3c_r <= sts3c_nxt;
      poll_r <= poll_nxt;
      irq_n_r <= irq_n_nxt;
    end
  end

  // ---------------- receive monitor ----------------
  logic [7:0] rx_acc_r, rx_acc_nxt;
  logic [7:0] rx_prev_r, rx_prev_nxt;
  logic [2:0] aux_cnt_r, aux_cnt_nxt;
  logic aux_cand_r, aux_cand_nxt;
  logic aux_state_nxt, aux_change_nxt;
  logic [3:0] bip_inc_nxt, far_inc_nxt;
  logic bip_event_nxt, far_event_nxt;
  pom_bip_rpt_t bip_rpt_r, bip_rpt_nxt;
  logic [7:0] rx_term, mismatch;
  logic [3:0] far_code;

  always_comb begin
    rx_acc_nxt = rx_acc_r;
    rx_prev_nxt = rx_prev_r;
    aux_cnt_nxt = aux_cnt_r;
    aux_cand_nxt = aux_cand_r;
    aux_state_nxt = aux_defect_state_r;
    aux_change_nxt = 1'b0;
    bip_inc_nxt = 4'h0;
    far_inc_nxt = 4'h0;
    bip_event_nxt = 1'b0;
    far_event_nxt = 1'b0;
    bip_rpt_nxt = '0;
    rx_term = 8'h00;
    mismatch = 8'h00;
    far_code = rx_byte_in.data[7:4];
    if (rx_byte_in.valid) begin
      // fixed stuff only exists in the sts-1 mapping
      if (rx_byte_in.spe && !(ring_r[RX_STUFF_SKIP_BIT] && !sts3c_r &&
          is_stuff_col(rx_byte_in.col))) begin
        rx_term = rx_byte_in.data;
      end
      if (rx_byte_in.frame_start) begin
        rx_prev_nxt = rx_acc_r;
        rx_acc_nxt = rx_term;
      end else begin
        rx_acc_nxt = rx_acc_r ^ rx_term;
      end
      if (rx_byte_in.b3) begin
        mismatch = rx_byte_in.data ^ rx_prev_r;
        bip_event_nxt = |mismatch;
        bip_inc_nxt = ring_r[BIP_COUNT_BLOCK_BIT] ? {3'h0, |mismatch} : ones8(mismatch);
        bip_rpt_nxt.valid = 1'b1;
        bip_rpt_nxt.count = ring_r[BIP_REPORT_BLOCK_BIT] ? {3'h0, |mismatch} :
                            ones8(mismatch);
      end
      if (rx_byte_in.g1) begin
        if (aux_ctrl_r[FAR_BLOCK_BIT]) begin
          far_inc_nxt = {3'h0, (far_code != 4'h0) && (far_code <= FAR_CODE_MAX)};
        end else begin
          far_inc_nxt = (far_code <= FAR_CODE_MAX) ? far_code : 4'h0;
        end
        far_event_nxt = |far_inc_nxt;
        if (rx_byte_in.data[3] != aux_cand_r) begin
          aux_cand_nxt = rx_byte_in.data[3];
          aux_cnt_nxt = 3'h1;
        end else if (aux_cnt_r != AUX_FILTER_FRAMES) begin
          aux_cnt_nxt = aux_cnt_r + 3'h1;
        end
        if (aux_cnt_nxt == AUX_FILTER_FRAMES && aux_cand_nxt != aux_defect_state_r) begin
          aux_state_nxt = aux_cand_nxt;
          aux_change_nxt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rx_acc_r <= 8'h00;
      rx_prev_r <= 8'h00;
      aux_cnt_r <= 3'h0;
      aux_cand_r <= 1'b0;
      aux_defect_state_r <= 1'b0;
      aux_change_r <= 1'b0;
      bip_inc_r <= 4'h0;
      far_inc_r <= 4'h0;
      bip_event_r <= 1'b0;
      far_event_r <= 1'b0;
      bip_rpt_r <= '0;
    end else begin
      rx_acc_r <= rx_acc_nxt;
      rx_prev_r <= rx_prev_nxt;
      aux_cnt_r <= aux_cnt_nxt;
      aux_cand_r <= aux_cand_nxt;
      aux_defect_state_r <= aux_state_nxt;
      aux_change_r <= aux_change_nxt;
      bip_inc_r <= bip_inc_nxt;
      far_inc_r <= far_inc_nxt;
      bip_event_r <= bip_event_nxt;
      far_event_r <= far_event_nxt;
      bip_rpt_r <= bip_rpt_nxt;
    end
  end

  pom_label_filter u_label (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .label_valid_in(rx_byte_in.valid && rx_byte_in.c2),
    .label_in(rx_byte_in.data),
    .label_value_out(label_value),
    .change_out(label_change)
  );

  pom_err_counter u_bip_count (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .inc_in(bip_inc_r),
    .snap_in(poll_r),
    .count_out(bip_err_count)
  );

  pom_err_counter u_far_count (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .inc_in(far_inc_r),
    .snap_in(poll_r),
    .count_out(far_err_count)
  );

  // ---------------- pointer indication qualifier ----------------
  logic [1:0] since_r, since_nxt;
  pom_ptr_ind_t ind_r, ind_nxt;
  logic size_bad;

  always_comb begin
    size_bad = ring_r[SIZE_CHECK_BIT] && (ptr_raw_in.size_bits != SIZE_BITS_OK);
    ind_nxt.new_flag_ind = ptr_raw_in.new_flag_ind && !size_bad;
    ind_nxt.new_point = ptr_raw_in.new_point && !size_bad;
    ind_nxt.inc_ind = ptr_raw_in.inc_ind && !size_bad &&
                      (!ring_r[STUFF_SPACING_BIT] || since_r == STUFF_SPACING_FRAMES);
    ind_nxt.dec_ind = ptr_raw_in.dec_ind && !size_bad &&
                      (!ring_r[STUFF_SPACING_BIT] || since_r == STUFF_SPACING_FRAMES);
    since_nxt = since_r;
    if (rx_byte_in.valid && rx_byte_in.frame_start && since_r != STUFF_SPACING_FRAMES) begin
      since_nxt = since_r + 2'h1;
    end
    if (|ind_nxt) begin
      since_nxt = 2'h0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      since_r <= STUFF_SPACING_FRAMES;
      ind_r <= '0;
    end else begin
      since_r <= since_nxt;
      ind_r <= ind_nxt;
    end
  end

  // ---------------- transmit insertion ----------------
  logic alarm_s1_r, alarm_s2_r, alarm_s3_r, alarm_r, alarm_nxt;
  logic [7:0] tx_acc_r, tx_acc_nxt;
  logic [7:0] tx_prev_r, tx_prev_nxt;
  pom_byte_t tx_out_r, tx_out_nxt;
  logic [7:0] tx_term, b3_err;

  always_comb begin
    alarm_nxt = (alarm_s2_r == alarm_s3_r) ? alarm_s3_r : alarm_r;
    tx_out_nxt = tx_byte_in;
    tx_acc_nxt = tx_acc_r;
    tx_prev_nxt = tx_prev_r;
    tx_term = 8'h00;
    // b3 invert takes precedence over the external mask
    b3_err = tx_ctrl_r[B3_INVERT_BIT] ? 8'hff : (tx_overhead_insert_en_in ? tx_b3_mask_in : 8'h00);
    if (tx_byte_in.b3) begin
      tx_out_nxt.data = tx_prev_r ^ b3_err;
    end
    if ((tx_ctrl_r[ALARM_FORCE_BIT] || alarm_r) && (tx_byte_in.spe || tx_byte_in.ptr)) begin
      tx_out_nxt.data = 8'hff;
    end
    if (tx_byte_in.valid) begin
      if (tx_byte_in.spe && !(tx_ctrl_r[TX_STUFF_SKIP_BIT] && !sts3c_r &&
          is_stuff_col(tx_byte_in.col))) begin
        tx_term = tx_out_nxt.data;
      end
      if (tx_byte_in.frame_start) begin
        tx_prev_nxt = tx_acc_r;
        tx_acc_nxt = tx_term;
      end else begin
        tx_acc_nxt = tx_acc_r ^ tx_term;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      alarm_s1_r <= 1'b0;
      alarm_s2_r <= 1'b0;
      alarm_s3_r <= 1'b0;
      alarm_r <= 1'b0;
      tx_acc_r <= 8'h00;
      tx_prev_r <= 8'h00;
      tx_out_r <= '0;
    end else begin
      alarm_s1_r <= path_alarm_in;
      alarm_s2_r <= alarm_s1_r;
      alarm_s3_r <= alarm_s2_r;
      alarm_r <= alarm_nxt;
      tx_acc_r <= tx_acc_nxt;
      tx_prev_r <= tx_prev_nxt;
      tx_out_r <= tx_out_nxt;
    end
  end

  assign pready_out = pready_r;
  assign prdata_out = prdata_r;
  assign pslverr_out = pslverr_r;
  assign ptr_ind_out = ind_r;
  assign bip_rpt_out = bip_rpt_r;
  assign tx_byte_out = tx_out_r;
  assign irq_n_out = irq_n_r;

endmodule

// >>> pom_top_props.sv
/*
  Checker for the path overhead monitor: apb timing and stream latencies at the top ports.
  Assumes the master drops penable between transfers and one clock domain.
*/
module pom_top_props
  import pom_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // apb
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [11:0] paddr_in,
  input wire logic pready_out,
  input wire logic [31:0] prdata_out,
  input wire logic pslverr_out,
  // streams
  input wire pom_byte_t rx_byte_in,
  input wire pom_ptr_raw_t ptr_raw_in,
  input wire pom_ptr_ind_t ptr_ind_out,
  input wire pom_bip_rpt_t bip_rpt_out,
  input wire pom_byte_t tx_byte_in,
  input wire logic path_alarm_in,
  input wire pom_byte_t tx_byte_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);

  a_ready_wait: assert property ($rose(penable_in) && psel_in |=> pready_out)
    else $error("pready not one cycle after access");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready held too long");
  a_err_align: assert property (pready_out && paddr_in[1:0] != 2'h0 |-> pslverr_out)
    else $error("misaligned access not refused");
  a_read_upper: assert property (pready_out |-> prdata_out[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_bip_time: assert property (rx_byte_in.valid && rx_byte_in.b3 |=> bip_rpt_out.valid)
    else $error("bip report missing after b3");
  a_bip_range: assert property (bip_rpt_out.valid |-> bip_rpt_out.count <= 4'h8)
    else $error("bip report above eight");
  a_inc_cause: assert property (!ptr_raw_in.inc_ind |=> !ptr_ind_out.inc_ind)
    else $error("increment without raw cause");
  a_dec_cause: assert property (!ptr_raw_in.dec_ind |=> !ptr_ind_out.dec_ind)
    else $error("decrement without raw cause");
  // the alarm input crosses a synchroniser, so it is held before the fill is expected
  a_alarm_fill: assert property (path_alarm_in [*6] ##0 tx_byte_in.spe
    |=> tx_byte_out.data == 8'hff)
    else $error("alarm did not fill spe");
  a_tx_pass: assert property (!tx_byte_in.spe && !tx_byte_in.ptr && !tx_byte_in.b3
    |=> tx_byte_out == $past(tx_byte_in))
    else $error("non payload byte altered");

  c_refused: cover property (pready_out && pslverr_out);
  c_bip_err: cover property (bip_rpt_out.valid && bip_rpt_out.count != 4'h0);
  c_fill: cover property (tx_byte_out.spe && tx_byte_out.data == 8'hff);
endmodule

bind pom_top pom_top_props chk_u (
  .clock_in(clock_in), .reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in),
  .paddr_in(paddr_in), .pready_out(pready_out), .prdata_out(prdata_out),
  .pslverr_out(pslverr_out), .rx_byte_in(rx_byte_in), .ptr_raw_in(ptr_raw_in),
  .ptr_ind_out(ptr_ind_out), .bip_rpt_out(bip_rpt_out), .tx_byte_in(tx_byte_in),
  .path_alarm_in(path_alarm_in), .tx_byte_out(tx_byte_out)
);

// >>> pom_path_src.sv
/*
  Far-end path byte source: four-byte frames carrying label, status and parity bytes.
  Assumes the bench requests frames through send_frame on the monitor's clock.
*/
module pom_path_src
  import pom_pkg::*;
(
  // clock
  input wire logic clock_in,
  // stream toward the monitor
  output pom_byte_t byte_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] par_r;

  initial begin
    par_r = 8'h00;
    byte_out = '0;
  end

  // parity byte covers the previous frame, flipped where err is set
  task automatic send_frame(input logic [7:0] c2, input logic [7:0] g1, input logic [7:0] err);
    pom_byte_t b;
    logic [7:0] d [4];
    d = '{8'h5c, c2, g1, par_r ^ err};
    for (int i = 0; i < 4; i++) begin
      b = '{frame_start: i == 0, valid: 1'b1, col: 7'(i + 1), spe: i < 3, ptr: 1'b0,
        c2: i == 1, g1: i == 2, b3: i == 3, data: d[i]};
      @(posedge clock_in);
      byte_out <= b;
    end
    par_r = 8'h5c ^ c2 ^ g1;
    repeat (4) begin
      @(posedge clock_in);
      // idle line toggles so a stale byte is never seen as held
      byte_out <= '{valid: 1'b0, data: ~byte_out.data, default: '0};
    end
  endtask
endmodule

// >>> pom_top_bench.sv
/*
  Self-checking bench for the path overhead monitor: apb master tasks and scenarios.
  Assumes the path byte source model and the bound checker are compiled alongside.
*/
module pom_top_bench
  import pom_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in, reset_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic path_alarm_in, irq_n_out, err;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  pom_byte_t rx_byte, tx_byte_in, tx_byte_out;
  pom_ptr_raw_t ptr_raw_in;
  pom_ptr_ind_t ptr_ind_out;
  pom_bip_rpt_t bip_rpt_out;
  int num_errors, comparisons;
  logic [7:0] codes [3] = '{8'h90, 8'h30, 8'h80};

  pom_path_src src_u (.clock_in(clock_in), .byte_out(rx_byte));
  pom_top dut_u (
    .clock_in(clock_in), .reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
    .rx_byte_in(rx_byte), .ptr_raw_in(ptr_raw_in), .ptr_ind_out(ptr_ind_out),
    .bip_rpt_out(bip_rpt_out), .tx_byte_in(tx_byte_in), .path_alarm_in(path_alarm_in),
    .tx_overhead_insert_en_in(1'b1), .tx_b3_mask_in(8'h0f), .tx_byte_out(tx_byte_out),
    .irq_n_out(irq_n_out)
  );

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer; waits on pready under a bound
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    int n;
    @(posedge clock_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= addr;
    pwdata_in <= wd;
    @(posedge clock_in);
    penable_in <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clock_in);
      if (pready_out === 1'b1) break;
    end
    if (n == 16) begin
      check(32'h0, 32'h1);
      test_done();
    end
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    xfer(1'b1, {2'b00, idx, 2'b00}, d);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, {2'b00, idx, 2'b00}, 32'h0);
    check(rd, exp);
  endtask

  task automatic wait_irq(input logic exp);
    for (int n = 0; n < 10; n++) begin
      @(posedge clock_in);
      if (irq_n_out === exp) break;
    end
    check(irq_n_out, exp);
  endtask

  initial begin
    reset_in = 1'b1;
    {psel_in, penable_in, pwrite_in, path_alarm_in} = 4'h0;
    paddr_in = 12'h000;
    pwdata_in = 32'h0;
    ptr_raw_in = '0;
    tx_byte_in = '0;
    num_errors = 0;
    comparisons = 0;
    repeat (4) @(posedge clock_in);
    reset_in <= 1'b0;
    rd_chk(IDX_RX_RING_CTRL, {24'h0, RING_CTRL_RESET});
    rd_chk(IDX_AUX_DEFECT_CTRL, {24'h0, AUX_CTRL_RESET});
    rd_chk(IDX_PATH_LABEL, {24'h0, LABEL_RESET});
    xfer(1'b0, 12'h0f8, 32'h0);
    check(err, 1'b1);
    xfer(1'b0, 12'h0f5, 32'h0);
    check(err, 1'b1);
    $display("test reset done");
    src_u.send_frame(8'h13, 8'h00, 8'h00);
    rd_chk(IDX_PATH_LABEL, 32'h0);
    src_u.send_frame(8'h13, 8'h00, 8'h00);
    rd_chk(IDX_PATH_LABEL, 32'h13);
    wait_irq(1'b1);
    wr(IDX_IRQ_MASK, 32'h2);
    wait_irq(1'b0);
    wr(IDX_IRQ_STATUS, 32'h2);
    wait_irq(1'b1);
    wr(IDX_AUX_DEFECT_CTRL, 32'h2);
    repeat (4) src_u.send_frame(8'h13, 8'h08, 8'h00);
    rd_chk(IDX_AUX_DEFECT_CTRL, 32'h2);
    src_u.send_frame(8'h13, 8'h08, 8'h00);
    rd_chk(IDX_AUX_DEFECT_CTRL, 32'h3);
    wait_irq(1'b0);
    wr(IDX_IRQ_STATUS, 32'h1);
    wait_irq(1'b1);
    $display("test label and defect done");
    repeat (32) src_u.send_frame(8'h13, 8'h00, 8'hff);
    wr(IDX_BIP_LOW, 32'h0);
    rd_chk(IDX_BIP_LOW, 32'h0);
    rd_chk(IDX_BIP_HIGH, 32'h1);
    rd_chk(IDX_BIP_HIGH, 32'h1);
    wr(IDX_BIP_HIGH, 32'h0);
    rd_chk(IDX_BIP_HIGH, 32'h0);
    wr(IDX_RX_RING_CTRL, 32'h20);
    repeat (2) src_u.send_frame(8'h13, 8'h00, 8'h0f);
    wr(IDX_LOAD_METERS, 32'h0);
    rd_chk(IDX_BIP_LOW, 32'h2);
    $display("test bip count done");
    src_u.send_frame(8'h13, 8'h50, 8'h00);
    src_u.send_frame(8'h13, 8'h90, 8'h00);
    wr(IDX_FAR_LOW, 32'h0);
    rd_chk(IDX_FAR_LOW, 32'h5);
    rd_chk(IDX_FAR_HIGH, 32'h0);
    wr(IDX_AUX_DEFECT_CTRL, 32'h10);
    foreach (codes[i]) src_u.send_frame(8'h13, codes[i], 8'h00);
    wr(IDX_FAR_HIGH, 32'h0);
    rd_chk(IDX_FAR_LOW, 32'h2);
    $display("test far error count done");
    wr(IDX_RX_RING_CTRL, 32'hc0);
    // the third increment follows the second with no frame between, so spacing drops it
    for (int k = 0; k < 3; k++) begin
      @(posedge clock_in);
      ptr_raw_in <= '{inc_ind: 1'b1, size_bits: k ? 2'b10 : 2'b00, default: '0};
      @(posedge clock_in);
      ptr_raw_in <= '0;
      #1 check(ptr_ind_out.inc_ind, k == 1);
    end
    $display("test pointer done");
    // no frame start on the transmit side, so the parity of the previous frame stays zero
    for (int k = 0; k < 5; k++) begin
      wr(IDX_TX_PATH_DIAG_CTRL, {30'h0, k == 3, k == 0});
      path_alarm_in <= (k == 1);
      tx_byte_in <= '{valid: 1'b1, spe: k < 3, b3: k > 2, data: 8'h5a, default: '0};
      repeat (6) @(posedge clock_in);
      #1 check(tx_byte_out.data, k == 2 ? 32'h5a : k == 4 ? 32'h0f : 32'hff);
    end
    $display("test transmit alarm done");
    test_done();
  end
endmodule
